// ==== shared/hpa_sec_pkg.sv ====
// Shared constants, layouts and types of the SET MAX security command block.
package hpa_sec_pkg;

	// ************************************************************
	// Register byte offsets on the AHB-Lite port.
	// ************************************************************
	localparam logic [7:0] OFF_SUBCMD = 8'h00;
	localparam logic [7:0] OFF_DEVHEAD = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_FAULT = 8'h10;
	localparam logic [7:0] OFF_DATA = 8'h14;
	localparam logic [7:0] OFF_PROT = 8'h18;

	// ************************************************************
	// Command and subcommand codes.
	// ************************************************************
	localparam logic [7:0] OPC_SET_MAX = 8'hf9;
	localparam logic [7:0] SUB_SET_PW = 8'h01;
	localparam logic [7:0] SUB_LOCK = 8'h02;
	localparam logic [7:0] SUB_UNLOCK = 8'h03;
	localparam logic [7:0] SUB_FREEZE = 8'h04;

	// ************************************************************
	// Sector layout, counter load and reset values.
	// ************************************************************
	localparam logic [7:0] SECTOR_LAST_WORD = 8'hff;
	localparam logic [7:0] PW_FIRST_WORD = 8'h01;
	localparam logic [7:0] PW_LAST_WORD = 8'h10;
	localparam int PW_WORDS = 16;
	localparam logic [2:0] UNLOCK_TRIES = 3'h5;
	localparam logic [7:0] STATUS_RST = 8'h40;
	localparam logic [7:0] FAULT_RST = 8'h00;
	localparam logic [7:0] DEVHEAD_RST = 8'h00;

	// ************************************************************
	// Types.
	// ************************************************************
	typedef enum logic [1:0] {PROT_UNLOCKED = 2'b00, PROT_LOCKED = 2'b01,
		PROT_FROZEN = 2'b11} prot_e;
	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_XFER = 2'b01, PH_EXEC = 2'b11} phase_e;

	typedef struct packed {
		logic bsy;
		logic drdy;
		logic df;
		logic rsv4;
		logic drq;
		logic rsv2;
		logic rsv1;
		logic err;
	} status_s;

	typedef struct packed {
		logic [2:0] rsv7_5;
		logic idnf;
		logic rsv3;
		logic abrt;
		logic [1:0] rsv1_0;
	} fault_s;

	typedef struct packed {
		logic pw_valid;
		logic exhausted;
		logic rsv5;
		logic [2:0] tries;
		logic [1:0] state;
	} prot_view_s;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic mapped;
	} ahb_req_s;

endpackage : hpa_sec_pkg

// ==== hdl/hpa_set_max_security.sv ====
// Command logic for the SET MAX security commands behind an AHB-Lite register port.
`timescale 1ns/100ps
module hpa_set_max_security
	import hpa_sec_pkg::*;
#(
	parameter logic [7:0] NATIVE_MAX_OPC = 8'hf0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic set_max_address_go,
	output logic [1:0] prot_state
);

	// ************************************************************
	// AHB-Lite slave.
	// ************************************************************
	// Every transfer takes one wait state so that read data leaves a flop.
	ahb_req_s req;
	logic pend;
	logic [31:0] rd_data;

	wire take = hsel && hready && htrans[1];
	wire word_size = (hsize == 3'h2);
	wire wr = pend && req.write && req.mapped;
	wire wr_subcmd = wr && (req.addr == OFF_SUBCMD);
	wire wr_devhead = wr && (req.addr == OFF_DEVHEAD);
	wire wr_cmd = wr && (req.addr == OFF_CMD);
	wire wr_data = wr && (req.addr == OFF_DATA);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pend <= 1'b0;
			req <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end
		else if (ce)
		begin
			pend <= take;
			hreadyout <= !take;
			if (take)
				req <= '{addr: haddr[7:0], write: hwrite,
					mapped: (haddr[31:8] == 24'h0) && word_size};
			if (pend)
				hrdata <= rd_data;
		end
	end

	// ************************************************************
	// Task-file style registers.
	// ************************************************************
	logic [7:0] subcmd;
	logic [7:0] devhead;
	logic [7:0] cmd;
	status_s status;
	fault_s fault;
	prot_e prot;
	phase_e phase;
	logic as_sma;
	logic after_native;
	logic pw_valid;
	logic exhausted;
	logic [2:0] tries;
	logic [7:0] word_cnt;
	logic [PW_WORDS-1:0][15:0] rx_pw;
	logic [PW_WORDS-1:0][15:0] stored_pw;

	prot_view_s prot_view;
	assign prot_view = '{pw_valid: pw_valid, exhausted: exhausted, rsv5: 1'b0,
		tries: tries, state: prot};

	wire rd_ok = pend && !req.write && req.mapped;
	assign rd_data = !rd_ok ? 32'h0 :
		(req.addr == OFF_DEVHEAD) ? {24'h0, devhead} :
		(req.addr == OFF_STATUS) ? {24'h0, status} :
		(req.addr == OFF_FAULT) ? {24'h0, fault} :
		(req.addr == OFF_PROT) ? {24'h0, prot_view} : 32'h0;

	// ************************************************************
	// Command decode.
	// ************************************************************
	wire [7:0] new_opc = hwdata[7:0];
	wire start = wr_cmd && (phase == PH_IDLE);
	// A security code right after the native-max read is a set-max-address.
	wire new_as_sma = after_native && (new_opc == OPC_SET_MAX);
	wire new_needs_data = (new_opc == OPC_SET_MAX) && !new_as_sma &&
		((subcmd == SUB_SET_PW) || (subcmd == SUB_UNLOCK));

	wire is_sec = (cmd == OPC_SET_MAX) && !as_sma;
	wire is_set_pw = is_sec && (subcmd == SUB_SET_PW);
	wire is_lock = is_sec && (subcmd == SUB_LOCK);
	wire is_unlock = is_sec && (subcmd == SUB_UNLOCK);
	wire is_freeze = is_sec && (subcmd == SUB_FREEZE);
	wire is_native = (cmd == NATIVE_MAX_OPC);

	wire pw_match = (rx_pw == stored_pw);

	wire ok_set_pw = is_set_pw && (prot == PROT_UNLOCKED);
	wire ok_lock = is_lock && (prot == PROT_UNLOCKED) && pw_valid;
	// Unlock is only examined while locked and not yet exhausted.
	wire try_unlock = is_unlock && (prot == PROT_LOCKED) && !exhausted;
	wire ok_unlock = try_unlock && pw_match;
	wire miss_unlock = try_unlock && !pw_match;
	wire ok_freeze = is_freeze && (prot == PROT_LOCKED);
	wire ok_sma = as_sma && (prot == PROT_UNLOCKED);

	wire cmd_ok = ok_set_pw || ok_lock || ok_unlock || ok_freeze || ok_sma || is_native;

	status_s done_status;
	fault_s done_fault;
	assign done_fault = '{rsv7_5: 3'h0, idnf: 1'b0, rsv3: 1'b0, abrt: !cmd_ok,
		rsv1_0: 2'h0};
	assign done_status = '{bsy: 1'b0, drdy: 1'b1, df: 1'b0, rsv4: 1'b0, drq: 1'b0,
		rsv2: 1'b0, rsv1: 1'b0, err: done_fault.abrt || done_fault.idnf};

	wire [7:0] pw_ofs = word_cnt - PW_FIRST_WORD;
	wire in_pw = (word_cnt >= PW_FIRST_WORD) && (word_cnt <= PW_LAST_WORD);

	// ************************************************************
	// Register writes from software.
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			subcmd <= 8'h0;
			devhead <= DEVHEAD_RST;
		end
		else if (ce)
		begin
			if (wr_subcmd && (phase == PH_IDLE))
				subcmd <= hwdata[7:0];
			if (wr_devhead && (phase == PH_IDLE))
				devhead <= hwdata[7:0];
		end
	end

	// ************************************************************
	// Command sequencer.
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase <= PH_IDLE;
			cmd <= 8'h0;
			as_sma <= 1'b0;
			word_cnt <= 8'h0;
			status <= STATUS_RST;
			fault <= FAULT_RST;
		end
		else if (ce)
		begin
			unique case (phase)
				PH_IDLE:
				begin
					if (start)
					begin
						cmd <= new_opc;
						as_sma <= new_as_sma;
						word_cnt <= 8'h0;
						phase <= new_needs_data ? PH_XFER : PH_EXEC;
						status <= new_needs_data ? 8'h48 : 8'hc0;
					end
				end
				PH_XFER:
				begin
					if (wr_data)
					begin
						word_cnt <= word_cnt + 8'h1;
						if (word_cnt == SECTOR_LAST_WORD)
						begin
							phase <= PH_EXEC;
							status <= 8'hc0;
						end
					end
				end
				PH_EXEC:
				begin
					status <= done_status;
					fault <= done_fault;
					phase <= PH_IDLE;
				end
				default:
					phase <= PH_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Sector capture.
	// ************************************************************
	// Only the password words are kept; the reserved words are counted and dropped.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rx_pw <= '0;
		else if (ce && (phase == PH_XFER) && wr_data && in_pw)
			rx_pw[pw_ofs[3:0]] <= hwdata[15:0];
	end

	// ************************************************************
	// Protection state, password and attempt counter.
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prot <= PROT_UNLOCKED;
			pw_valid <= 1'b0;
			stored_pw <= '0;
			tries <= 3'h0;
			exhausted <= 1'b0;
			after_native <= 1'b0;
			set_max_address_go <= 1'b0;
		end
		else if (ce)
		begin
			set_max_address_go <= (phase == PH_EXEC) && ok_sma;
			if (phase == PH_EXEC)
			begin
				after_native <= is_native;
				if (ok_set_pw)
				begin
					stored_pw <= rx_pw;
					pw_valid <= 1'b1;
				end
				if (ok_lock)
				begin
					prot <= PROT_LOCKED;
					tries <= UNLOCK_TRIES;
				end
				if (ok_unlock)
					prot <= PROT_UNLOCKED;
				if (ok_freeze)
					prot <= PROT_FROZEN;
				if (miss_unlock)
				begin
					tries <= tries - 3'h1;
					// Exhaustion is sticky so that a later lock cannot reopen unlock.
					if (tries <= 3'h1)
						exhausted <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prot_state <= PROT_UNLOCKED;
		else if (ce)
			prot_state <= prot;
	end

endmodule : hpa_set_max_security

// ==== verif/hpa_host_model.sv ====
// Host adapter model issuing single AHB-Lite word transfers.
`timescale 1ns/100ps
module hpa_host_model (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'h2,
	output logic [31:0] hwdata = 32'h0
);
	// Called just after a rising edge; every phase is held until hready is seen high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		q = hrdata;
	endtask : xfer
endmodule : hpa_host_model

// ==== verif/hpa_sec_properties.sv ====
// Port checks of the SET MAX security block.
`timescale 1ns/100ps
module hpa_sec_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic set_max_address_go,
	input wire logic [1:0] prot_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
	wait_state_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("wait state not one cycle");
	reset_view_a: assert property (disable iff (1'b0) !rst_n |=> prot_state == 2'b00
		&& !set_max_address_go && hreadyout) else $error("bad state after reset");
	state_code_a: assert property (prot_state != 2'b10) else $error("bad state code");
	frozen_hold_a: assert property (prot_state == 2'b11 |=> prot_state == 2'b11)
		else $error("frozen state left");
	freeze_entry_a: assert property ($changed(prot_state) && prot_state == 2'b11
		|-> $past(prot_state) == 2'b01) else $error("frozen not from locked");
	lock_entry_a: assert property ($changed(prot_state) && prot_state == 2'b01
		|-> $past(prot_state) == 2'b00) else $error("locked not from unlocked");
	go_pulse_a: assert property (set_max_address_go |=> !set_max_address_go)
		else $error("go longer than one cycle");
	go_unlocked_a: assert property (set_max_address_go |-> prot_state == 2'b00)
		else $error("go outside unlocked");
endmodule : hpa_sec_checker
bind hpa_set_max_security hpa_sec_checker u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.set_max_address_go(set_max_address_go), .prot_state(prot_state));

// ==== verif/hpa_set_max_security_test.sv ====
// Self-checking bench of the SET MAX security command block.
`timescale 1ns/100ps
module hpa_set_max_security_test import hpa_sec_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int go_count = 0;
	logic hsel, hwrite, hreadyout, hresp, set_max_address_go;
	logic [31:0] haddr, hwdata, hrdata, q, junk;
	logic [1:0] htrans, prot_state;
	logic [2:0] hsize;
	int n_errors = 0;
	int comparisons = 0;
	always #2 clk = ~clk;
	// Counted rather than flagged so that only this process ever writes it.
	always @(posedge clk) if (set_max_address_go) go_count <= go_count + 1;
	hpa_host_model u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	hpa_set_max_security u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.set_max_address_go(set_max_address_go), .prot_state(prot_state));
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, junk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	task automatic view(input logic [7:0] exp, input logic [7:0] mask);
		rd(OFF_PROT);
		chk(q[7:0] & mask, exp);
		chk({6'h0, prot_state}, {6'h0, exp[1:0]});
	endtask : view
	// Runs one command to completion; a data request is answered with a full sector.
	task automatic cmd(input logic [7:0] sub, input logic [7:0] opc, input logic [15:0] key,
		input logic [7:0] st);
		int n;
		wr(OFF_SUBCMD, {24'h0, sub});
		wr(OFF_CMD, {24'h0, opc});
		rd(OFF_STATUS);
		if (q[3] === 1'b1)
			for (n = 0; n < 256; n++)
				wr(OFF_DATA, {16'h0, (n >= 1 && n <= 16) ? key ^ 16'(n) : 16'h5a5a});
		rd(OFF_STATUS);
		for (n = 0; n < 8 && (q[7] | q[3]) === 1'b1; n++)
			rd(OFF_STATUS);
		chk(q[7:0], st);
		rd(OFF_FAULT);
		chk(q[7:0], {5'h0, st[0], 2'h0});
	endtask : cmd
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFF_STATUS);
		chk(q[7:0], STATUS_RST);
		view(8'h00, 8'hff);
		wr(OFF_DEVHEAD, 32'h10);
		rd(OFF_DEVHEAD);
		chk(q[7:0], 8'h10);
		rd(8'h40);
		chk(q[7:0], 8'h00);
		cmd(SUB_FREEZE, OPC_SET_MAX, 16'h0, 8'h41);
		cmd(8'h00, 8'hf0, 16'h0, 8'h40);
		chk(go_count[7:0], 8'h00);
		cmd(SUB_LOCK, OPC_SET_MAX, 16'h0, 8'h40);
		chk(go_count[7:0], 8'h01);
		view(8'h00, 8'h03);
		cmd(SUB_SET_PW, OPC_SET_MAX, 16'h1234, 8'h40);
		view(8'h80, 8'hff);
		cmd(SUB_LOCK, OPC_SET_MAX, 16'h0, 8'h40);
		view(8'h95, 8'hff);
		cmd(SUB_SET_PW, OPC_SET_MAX, 16'h9999, 8'h41);
		cmd(SUB_UNLOCK, OPC_SET_MAX, 16'h1235, 8'h41);
		view(8'h91, 8'hff);
		cmd(SUB_UNLOCK, OPC_SET_MAX, 16'h1234, 8'h40);
		view(8'h00, 8'h03);
		cmd(SUB_LOCK, OPC_SET_MAX, 16'h0, 8'h40);
		view(8'h95, 8'hff);
		repeat (5) cmd(SUB_UNLOCK, OPC_SET_MAX, 16'h0bad, 8'h41);
		view(8'hc1, 8'hff);
		cmd(SUB_UNLOCK, OPC_SET_MAX, 16'h1234, 8'h41);
		cmd(SUB_FREEZE, OPC_SET_MAX, 16'h0, 8'h40);
		view(8'hc3, 8'hff);
		cmd(SUB_LOCK, OPC_SET_MAX, 16'h0, 8'h41);
		cmd(SUB_SET_PW, OPC_SET_MAX, 16'h1234, 8'h41);
		end_of_test();
	end
	initial
	begin
		#60000;
		n_errors++;
		end_of_test();
	end
endmodule : hpa_set_max_security_test
